/* manchester_message_decoder_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// Self-checking bench for the message decoder
// ********
module manchester_message_decoder_test;
  import mmd_pkg::*;
  localparam int HALF = 8; // Half-bit length on the line
  localparam int PER = 50; // Strobe period in core cycles
  localparam int RATIO[4] = '{3, 7, 15, 31}; // Sleep periods per code
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic strobeIn = 1'b0;
  logic demodData;
  logic [31:0] prdata;
  logic pready, pslverr, runMode, dataOut, serialClkOut, messageActive;
  int errorCnt = 0;
  int testsRun = 0;
  int cyc = 0;
  logic [32:0] rdQ[$]; // Expected {error, data} per read
  logic bitQ[$]; // Expected payload bits
  logic [31:0] rng = 32'hE7B9; // Fixed seed
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  mmd_message_decoder #(.SETTLE_COUNT(20)) u_dut (
    .core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .demodData, .strobeIn, .runMode, .dataOut,
    .serialClkOut, .messageActive);
  mmd_tx_model #(.HALF(HALF)) u_tx (.core_clk, .line(demodData));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction
  task automatic cmpWord(input string what, input logic [32:0] e, input logic [32:0] g);
    testsRun++;
    if (g !== e) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmpBit(input logic e, input logic g);
    testsRun++;
    if (g !== e) begin
      errorCnt++;
      $display("BAD payload bit expected %b seen %b", e, g);
    end
  endtask
  // One transfer; entered just after an edge, leaves one idle edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rdQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // Bounded wait for a run level
  task automatic waitLvl(input logic lvl);
    int n;
    n = 0;
    while (runMode !== lvl && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic frame(input logic [7:0] id, input logic hdr, input logic inv, input logic good);
    logic [7:0] pay;
    rng = xs(rng);
    pay = rng[7:0];
    u_tx.sendByte(8'hAA); // Preamble free of id and header
    u_tx.sendByte(id);
    if (hdr) u_tx.sendNib(inv ? 4'h9 : 4'h6);
    for (int i = 7; i >= 0; i--) if (good) bitQ.push_back(pay[i] ^ inv);
    u_tx.sendByte(pay);
    u_tx.sendEom();
    repeat (6 * HALF) @(posedge core_clk);
    cmpWord("bits missing", 33'h0, 33'(bitQ.size()));
    bitQ.delete();
    $display("test frame %h done", id);
  endtask
  // Read results, taken at the completing edge
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite) cmpWord("read", rdQ.pop_front(), {pslverr, prdata});
  end
  // Payload results, one per strobe
  always @(posedge core_clk) begin
    if (serialClkOut === 1'b1) begin
      if (bitQ.size() == 0) cmpWord("extra bit", 33'h0, 33'h1);
      else cmpBit(bitQ.pop_front(), dataOut);
    end
  end
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge core_clk);
    errorCnt++;
    $display("watchdog expired");
    wrapUp();
  end
  initial begin
    int t0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(ADDR_CTRL, 33'h014);
    rd(ADDR_IDENT, 33'h0);
    rd(ADDR_HALFBIT, {17'h0, RST_HALFBIT});
    rd(ADDR_STROBE, {9'h0, RST_STROBE});
    rd(12'h014, 33'h100000000);
    $display("test reset values done");
    apb(1'b1, ADDR_STROBE, 32'(PER));
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, ADDR_CTRL, 32'(32'h10 | (c << 2)));
      waitLvl(1'b0);
      waitLvl(1'b1);
      t0 = cyc;
      waitLvl(1'b0);
      waitLvl(1'b1);
      cmpWord("cycle", 33'((RATIO[c] + 1) * PER), 33'(cyc - t0));
    end
    rd(ADDR_CTRL, 33'h01C);
    rd(ADDR_STROBE, 33'(PER));
    $display("test strobe ratios done");
    apb(1'b1, ADDR_CTRL, 32'h0);
    repeat (20) @(posedge core_clk);
    cmpWord("run off", 33'h0, {32'h0, runMode});
    strobeIn <= 1'b1;
    repeat (3) @(posedge core_clk);
    cmpWord("run on", 33'h1, {32'h0, runMode});
    $display("test strobe pin done");
    apb(1'b1, ADDR_HALFBIT, 32'(HALF));
    apb(1'b1, ADDR_IDENT, 32'hF0);
    apb(1'b1, ADDR_CTRL, 32'h03);
    frame(8'hF0, 1'b1, 1'b0, 1'b1);
    frame(8'h0F, 1'b1, 1'b1, 1'b1);
    frame(8'hF0, 1'b1, 1'b0, 1'b1);
    frame(8'hE0, 1'b1, 1'b0, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h02);
    frame(8'hF0, 1'b0, 1'b0, 1'b1);
    // Internal strobe with a header expected: an identifier seen in
    // the run slot must hold run until the message ends
    apb(1'b1, ADDR_STROBE, 32'(8 * PER));
    apb(1'b1, ADDR_CTRL, 32'h13);
    strobeIn <= 1'b0;
    u_tx.sendByte(8'hAA);
    fork
      repeat (20) u_tx.sendByte(8'hF0);
      begin
        waitLvl(1'b1);
        repeat (12 * PER) @(posedge core_clk);
        cmpWord("run held", 33'h1, {32'h0, runMode});
      end
    join
    u_tx.sendEom();
    repeat (8 * PER + 16) @(posedge core_clk);
    cmpWord("run released", 33'h0, {32'h0, runMode});
    $display("test run hold done");
    apb(1'b1, ADDR_CTRL, 32'h00);
    frame(8'hF0, 1'b1, 1'b0, 1'b0);
    wrapUp();
  end
endmodule
`default_nettype wire

/* mmd_bit_recovery.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Manchester bit and clock recovery
// ****************************************************************
module mmd_bit_recovery (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic [15:0] halfBitCycles,
  input wire logic lineIn,
  output mmd_pkg::mmd_bit_type bitOut
);
  import mmd_pkg::*;

  logic lineReg; // Previous line level
  logic lastMidReg; // Last edge was a mid-bit edge
  logic syncReg; // Locked onto the bit stream
  logic [17:0] gapReg; // Cycles since last edge
  logic lineEdge;
  logic [17:0] longLimit; // 1.5 half bits: only mid edges are this far apart
  logic [17:0] endLimit; // 3 half bits: no valid Manchester gap is this long

  assign lineEdge = lineIn != lineReg;
  assign longLimit = {2'h0, halfBitCycles} + {3'h0, halfBitCycles[15:1]};
  assign endLimit = {1'h0, halfBitCycles, 1'h0} + {2'h0, halfBitCycles};

  // Edge classification; every mid-bit edge yields one bit
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lineReg <= 1'b0;
      lastMidReg <= 1'b0;
      syncReg <= 1'b0;
      gapReg <= 18'h00000;
      bitOut <= '0;
    end else if (!enable) begin
      // Idle while disabled, lose lock
      lineReg <= lineIn;
      lastMidReg <= 1'b0;
      syncReg <= 1'b0;
      gapReg <= 18'h00000;
      bitOut <= '0;
    end else begin
      lineReg <= lineIn;
      bitOut <= '0;
      if (lineEdge) begin
        gapReg <= 18'h00000;
        if (gapReg >= longLimit || !lastMidReg) begin
          // Mid edge: first half held the true value
          bitOut.valid <= 1'b1;
          bitOut.value <= lineReg;
          lastMidReg <= 1'b1;
          syncReg <= 1'b1;
        end else begin
          // Short edge after a mid edge is a bit boundary
          lastMidReg <= 1'b0;
        end
      end else if (gapReg != endLimit) begin
        gapReg <= gapReg + 18'h00001;
      end else if (syncReg) begin
        // Two equal unencoded bits hold the line past any Manchester gap
        bitOut.msgEnd <= 1'b1;
        syncReg <= 1'b0;
        lastMidReg <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* mmd_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// Port checks for the message decoder
// ********
module mmd_checker #(
  parameter int SETTLE_COUNT = 20
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic demodData,
  input wire logic strobeIn,
  input wire logic runMode,
  input wire logic dataOut,
  input wire logic serialClkOut,
  input wire logic messageActive
);
  import mmd_pkg::*;
  logic data_manager_enable, strobe_osc_enable; // Shadow control bits
  logic [1:0] ratioCode; // Shadow ratio code
  logic [31:0] halfLen, perLen, sleepLimit; // Shadow lengths
  logic [31:0] sleepCnt, runCnt, quietCnt; // Run-length counters
  logic lastData; // Line one cycle ago
  logic cfgWr; // Completed register write
  assign cfgWr = psel && penable && pwrite;
  // Longest legal sleep; two cycles slack for the output register
  assign sleepLimit = ((32'h4 << ratioCode) - 32'h1) * perLen + 32'h2;
  // Track configuration as written over the bus
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_manager_enable <= RST_DME;
      strobe_osc_enable <= RST_SOE;
      ratioCode <= RST_SR;
      halfLen <= 32'(RST_HALFBIT);
      perLen <= 32'(RST_STROBE);
    end else if (cfgWr) begin
      if (paddr == ADDR_CTRL) begin
        data_manager_enable <= pwdata[CTRL_DME_BIT];
        strobe_osc_enable <= pwdata[CTRL_SOE_BIT];
        ratioCode <= pwdata[CTRL_SR_LSB +: 2];
      end
      if (paddr == ADDR_HALFBIT) halfLen <= {16'h0, pwdata[15:0]};
      if (paddr == ADDR_STROBE) perLen <= {8'h0, pwdata[23:0]};
    end
  end
  // Count sleep, run and quiet-line cycles; a write restarts sleep
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sleepCnt <= 32'h0;
      runCnt <= 32'h0;
      quietCnt <= 32'h0;
      lastData <= 1'b0;
    end else begin
      sleepCnt <= (runMode || cfgWr) ? 32'h0 : sleepCnt + 32'h1;
      runCnt <= runMode ? runCnt + 32'h1 : 32'h0;
      quietCnt <= (demodData != lastData) ? 32'h0 : quietCnt + 32'h1;
      lastData <= demodData;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  sequence dmeOff;
    !data_manager_enable ##1 !data_manager_enable;
  endsequence
  raw_path_a: assert property (dmeOff |-> dataOut == $past(demodData))
    else $error("raw output is not the line delayed one cycle");
  idle_when_off_a: assert property (dmeOff |-> !serialClkOut)
    else $error("payload strobe with decoding off");
  strobe_force_a: assert property (strobeIn |=> runMode)
    else $error("strobe input did not force run");
  settle_gate_a: assert property (serialClkOut |-> runCnt > SETTLE_COUNT)
    else $error("payload before settling window");
  pulse_single_a: assert property (serialClkOut |=> !serialClkOut)
    else $error("payload strobe longer than one cycle");
  payload_active_a: assert property (serialClkOut |-> messageActive)
    else $error("payload strobe outside a message");
  end_quiet_a: assert property (quietCnt > 3 * halfLen + 8 |-> !messageActive)
    else $error("message still active on a quiet line");
  sleep_bound_a: assert property (strobe_osc_enable && !runMode |-> sleepCnt <= sleepLimit)
    else $error("sleep longer than ratio periods");
endmodule
bind mmd_message_decoder mmd_checker #(.SETTLE_COUNT(SETTLE_COUNT)) u_chk (
  .core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .demodData,
  .strobeIn, .runMode, .dataOut, .serialClkOut, .messageActive);
`default_nettype wire

/* mmd_message_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Manchester: true half, then inverted half
// - Decoding runs only with data manager enabled
// - Match received byte against stored identifier
// - Inverted identifier also counts as match
// - Header is 0110 or its inverse 1001
// - Payload starts right after last header bit
// - Two equal unencoded bits end the message
// - Inverted header inverts every output payload bit
// - Stay running only if identifier seen
// - Internal timer: sleep ratio periods, run one
// - Strobe pin high always forces run mode
// - Configuration survives sleep mode unchanged
// - Data valid only after settling window
// - Output raw data or managed serial data
// - Power-on defaults work without host setup
// - Ratio codes give 3, 7, 15, 31
// - Header enable matters only with manager on
module mmd_message_decoder #(
  parameter int SETTLE_COUNT = mmd_pkg::SETTLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic demodData,
  input wire logic strobeIn,
  output logic runMode,
  output logic dataOut,
  output logic serialClkOut,
  output logic messageActive
);
  import mmd_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************

  // All logic runs on core_clk; the line input is taken as already
  // synchronous, so no resync stage is spent on it
  // Framing states
  typedef enum logic [2:0] {
    SEARCH_ID = 3'b001,
    SEEK_HEADER = 3'b010,
    PAYLOAD = 3'b100
  } mmd_state_type;

  mmd_state_type stateReg; // Framing state
  mmd_state_type stateNext;
  mmd_cfg_type cfgReg; // Software configuration
  mmd_bit_type bitEvt; // Recovered bit stream
  logic [7:0] shiftReg; // Last eight recovered bits, newest in bit 0
  logic invertReg; // Header came inverted
  logic [17:0] settleReg; // Wake-up settling counter
  logic settledReg; // Settling window over
  logic runPrevReg; // Run mode one cycle ago
  logic decodeEnable; // Bit recovery may run
  logic keepRun; // Identifier seen in this run slot
  logic [7:0] shiftNext;
  logic idMatch;
  logic headerMatch;
  logic headerInverted;
  logic accessPhase;
  logic setupPhase;

  // ****************************************************************
  // Register bus
  // ****************************************************************

  // Address decode used only by the error flag, which marks unmapped reads and writes alike
  function automatic logic addrMapped(input logic [11:0] addr);
    addrMapped = addr == ADDR_CTRL || addr == ADDR_IDENT ||
      addr == ADDR_HALFBIT || addr == ADDR_STROBE || addr == ADDR_STATUS;
  endfunction

  assign setupPhase = psel & ~penable;
  assign accessPhase = psel & penable;
  // APB always has a setup cycle, so preparing read data there costs
  // one register and no wait state
  // Zero wait states: read data is prepared during setup
  assign pready = 1'b1;

  // Fields are taken on the access cycle only, when the write data
  // is known to be final
  // Configuration writes; sleep never touches these
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // Standalone power-on configuration
      cfgReg.headerEnable <= RST_HE;
      cfgReg.dataManagerEnable <= RST_DME;
      cfgReg.strobeRatio <= RST_SR;
      cfgReg.strobeOscEnable <= RST_SOE;
      cfgReg.identifier <= RST_IDENT;
      cfgReg.halfBitCycles <= RST_HALFBIT;
      cfgReg.strobeCycles <= RST_STROBE;
    end else if (accessPhase && pwrite) begin
      case (paddr)
        ADDR_CTRL: begin
          cfgReg.headerEnable <= pwdata[CTRL_HE_BIT];
          cfgReg.dataManagerEnable <= pwdata[CTRL_DME_BIT];
          cfgReg.strobeRatio <= pwdata[CTRL_SR_LSB +: 2];
          cfgReg.strobeOscEnable <= pwdata[CTRL_SOE_BIT];
        end
        ADDR_IDENT: begin
          cfgReg.identifier <= pwdata[7:0];
        end
        ADDR_HALFBIT: begin
          cfgReg.halfBitCycles <= pwdata[15:0];
        end
        ADDR_STROBE: begin
          cfgReg.strobeCycles <= pwdata[23:0];
        end
        default: begin
          // Status is read-only, unmapped writes are dropped
        end
      endcase
    end
  end

  // The error flag drops with psel, so an idle bus shows no stale error
  // Read data and error flag, captured in the setup cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata <= 32'h00000000;
      pslverr <= ~addrMapped(paddr);
      case (paddr)
        ADDR_CTRL: begin
          prdata[CTRL_HE_BIT] <= cfgReg.headerEnable;
          prdata[CTRL_DME_BIT] <= cfgReg.dataManagerEnable;
          prdata[CTRL_SR_LSB +: 2] <= cfgReg.strobeRatio;
          prdata[CTRL_SOE_BIT] <= cfgReg.strobeOscEnable;
        end
        ADDR_IDENT: begin
          prdata[7:0] <= cfgReg.identifier;
        end
        ADDR_HALFBIT: begin
          prdata[15:0] <= cfgReg.halfBitCycles;
        end
        ADDR_STROBE: begin
          prdata[23:0] <= cfgReg.strobeCycles;
        end
        ADDR_STATUS: begin
          // Live block state for software
          prdata[ST_RUN_BIT] <= runMode;
          prdata[ST_SETTLED_BIT] <= settledReg;
          prdata[ST_INV_BIT] <= invertReg;
          prdata[ST_STATE_LSB +: 3] <= stateReg;
        end
        default: begin
          // Unmapped reads return zero with an error
        end
      endcase
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  // ****************************************************************
  // Power cycling and settling
  // ****************************************************************

  // The timer owns sleep and run; the framer only asks it to hold
  // the run slot while a telegram is being taken in
  // Framer holding the link counts as identifier seen
  assign keepRun = stateReg != SEARCH_ID;

  mmd_strobe_timer strobeTimer (
    .core_clk(core_clk),
    .reset(reset),
    .oscEnable(cfgReg.strobeOscEnable),
    .ratioCode(cfgReg.strobeRatio),
    .strobeCycles(cfgReg.strobeCycles),
    .keepRun(keepRun),
    .strobeIn(strobeIn),
    .runMode(runMode)
  );

  // Limitation: bits inside the window are lost, so an identifier
  // burst must last well beyond one window to be caught
  // Settling window restarts at every wake-up; the counter saturates
  // so a long run does not wrap back into the blind window
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      runPrevReg <= 1'b0;
      settleReg <= 18'h00000;
      settledReg <= 1'b0;
    end else begin
      runPrevReg <= runMode;
      if (!runMode || !runPrevReg) begin
        settleReg <= 18'h00000;
        settledReg <= 1'b0;
      end else if (settleReg >= 18'(SETTLE_COUNT - 1)) begin
        settledReg <= 1'b1;
      end else begin
        settleReg <= settleReg + 18'h00001;
      end
    end
  end

  // Decoding only when managed, awake and settled
  assign decodeEnable = cfgReg.dataManagerEnable & runMode & settledReg;

  // ****************************************************************
  // Bit recovery
  // ****************************************************************

  // Recovery keeps tracking the line level while disabled, so a stale
  // level cannot fake an edge at the moment decoding starts
  mmd_bit_recovery bitRecovery (
    .core_clk(core_clk),
    .reset(reset),
    .enable(decodeEnable),
    .halfBitCycles(cfgReg.halfBitCycles),
    .lineIn(demodData),
    .bitOut(bitEvt)
  );

  // ****************************************************************
  // Framing
  // ****************************************************************

  // Matching looks at shiftNext, so a word completed by this bit is
  // judged in the same cycle as the bit event
  // Newest bit enters at the bottom, so the byte reads MSB first
  assign shiftNext = {shiftReg[6:0], bitEvt.value};
  // True or complemented identifier
  assign idMatch = shiftNext == cfgReg.identifier ||
    shiftNext == ~cfgReg.identifier;
  // Four-bit header or its inverse
  assign headerMatch = shiftNext[3:0] == HEADER_WORD ||
    shiftNext[3:0] == ~HEADER_WORD;
  assign headerInverted = shiftNext[3:0] == ~HEADER_WORD;

  // Loss of enable wins over every transition, so a half-seen
  // telegram never leaks payload after a wake-up
  // Next framing state
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      SEARCH_ID: begin
        if (bitEvt.valid && idMatch) begin
          // Header only expected when enabled
          stateNext = cfgReg.headerEnable ? SEEK_HEADER : PAYLOAD;
        end
      end
      SEEK_HEADER: begin
        if (bitEvt.valid && headerMatch) begin
          stateNext = PAYLOAD;
        end
      end
      PAYLOAD: begin
        stateNext = PAYLOAD;
      end
      default: begin
        stateNext = SEARCH_ID;
      end
    endcase
    // End word or loss of enable restarts the search
    if (bitEvt.msgEnd || !decodeEnable) begin
      stateNext = SEARCH_ID;
    end
  end

  // One-hot codes let software read the state field as plain flags
  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stateReg <= SEARCH_ID;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Bit history; cleared at each state change so stale bits never match
  // This also stops identifier bits from completing a header
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      shiftReg <= 8'h00;
    end else if (stateNext != stateReg || bitEvt.msgEnd) begin
      shiftReg <= 8'h00;
    end else if (bitEvt.valid) begin
      shiftReg <= shiftNext;
    end
  end

  // Inversion is latched on the last header bit and cleared on every
  // return to search, so it never carries into the next telegram
  // Polarity of the current message
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      invertReg <= 1'b0;
    end else if (stateNext == SEARCH_ID) begin
      invertReg <= 1'b0;
    end else if (stateReg == SEEK_HEADER && bitEvt.valid && headerMatch) begin
      invertReg <= headerInverted;
    end
  end

  // ****************************************************************
  // Output port
  // ****************************************************************

  // The strobe lasts one cycle, but dataOut stands until the next
  // payload bit, so the host may sample it at any time before that
  // Raw comparator level when unmanaged, payload bits when managed
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dataOut <= 1'b0;
      serialClkOut <= 1'b0;
      messageActive <= 1'b0;
    end else begin
      serialClkOut <= 1'b0;
      messageActive <= stateReg == PAYLOAD;
      if (!cfgReg.dataManagerEnable) begin
        dataOut <= demodData;
      end else if (stateReg == PAYLOAD && bitEvt.valid) begin
        // First bit after header is payload, polarity fixed
        dataOut <= bitEvt.value ^ invertReg;
        serialClkOut <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* mmd_pkg.sv */
// ****************************************************************
// Shared constants and types for the message decoder
// ****************************************************************
package mmd_pkg;

  // Core clock rate and wake-up settling window
  localparam int CLK_FREQ_MHZ = 250;
  localparam int SETTLE_TIME_US = 1000;
  localparam int SETTLE_CYCLES = SETTLE_TIME_US * CLK_FREQ_MHZ;

  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_IDENT = 12'h004;
  localparam logic [11:0] ADDR_HALFBIT = 12'h008;
  localparam logic [11:0] ADDR_STROBE = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;

  // Control field positions
  localparam int CTRL_HE_BIT = 0;
  localparam int CTRL_DME_BIT = 1;
  localparam int CTRL_SR_LSB = 2;
  localparam int CTRL_SOE_BIT = 4;

  // Status field positions
  localparam int ST_RUN_BIT = 0;
  localparam int ST_SETTLED_BIT = 1;
  localparam int ST_INV_BIT = 2;
  localparam int ST_STATE_LSB = 4;

  // Power-on configuration: standalone raw-data receiver
  localparam logic RST_HE = 1'b0;
  localparam logic RST_DME = 1'b0;
  localparam logic [1:0] RST_SR = 2'h1;
  localparam logic RST_SOE = 1'b1;
  localparam logic [7:0] RST_IDENT = 8'h00;
  localparam logic [15:0] RST_HALFBIT = 16'h65BA;
  localparam logic [23:0] RST_STROBE = 24'h0F4240;

  // Header pattern, sent first bit first
  localparam logic [3:0] HEADER_WORD = 4'h6;

  // Configuration carrier
  typedef struct packed {
    logic headerEnable;
    logic dataManagerEnable;
    logic [1:0] strobeRatio;
    logic strobeOscEnable;
    logic [7:0] identifier;
    logic [15:0] halfBitCycles;
    logic [23:0] strobeCycles;
  } mmd_cfg_type;

  // Recovered bit event carrier
  typedef struct packed {
    logic valid;
    logic value;
    logic msgEnd;
  } mmd_bit_type;

  // Sleep periods for each ratio code
  function automatic logic [4:0] mmd_ratio(input logic [1:0] code);
    case (code)
      2'h0: mmd_ratio = 5'h03;
      2'h1: mmd_ratio = 5'h07;
      2'h2: mmd_ratio = 5'h0F;
      default: mmd_ratio = 5'h1F;
    endcase
  endfunction

endpackage

/* mmd_strobe_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Sleep/run strobe timer
// ****************************************************************
module mmd_strobe_timer (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic oscEnable,
  input wire logic [1:0] ratioCode,
  input wire logic [23:0] strobeCycles,
  input wire logic keepRun,
  input wire logic strobeIn,
  output logic runMode
);
  import mmd_pkg::*;

  logic [23:0] prescaleReg; // Models the strobe oscillator period
  logic [4:0] phaseReg; // Periods elapsed in this cycle
  logic tick;
  logic runSlot;

  assign tick = prescaleReg >= strobeCycles - 24'h000001;
  assign runSlot = phaseReg == mmd_ratio(ratioCode);

  // Period counter: ratio sleep periods, then one run period
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prescaleReg <= 24'h000000;
      phaseReg <= 5'h00;
    end else if (!oscEnable) begin
      prescaleReg <= 24'h000000;
      phaseReg <= 5'h00;
    end else if (tick) begin
      prescaleReg <= 24'h000000;
      if (phaseReg > mmd_ratio(ratioCode)) begin
        phaseReg <= 5'h00;
      end else if (runSlot) begin
        // Identifier found: hold the run slot, else back to sleep
        phaseReg <= keepRun ? phaseReg : 5'h00;
      end else begin
        phaseReg <= phaseReg + 5'h01;
      end
    end else begin
      prescaleReg <= prescaleReg + 24'h000001;
    end
  end

  // Strobe pin high forces run whatever the timer says
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      runMode <= 1'b0;
    end else begin
      runMode <= strobeIn | (oscEnable & runSlot);
    end
  end

endmodule
`default_nettype wire

/* mmd_tx_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// Remote transmitter sending Manchester telegrams
// ********
module mmd_tx_model #(
  parameter int HALF = 8
) (
  input wire logic core_clk,
  output logic line
);
  initial line = 1'b0; // Idle level before the first telegram
  // Hold one half-bit, changed just after an edge
  task automatic halfOut(input logic v);
    line <= v;
    repeat (HALF) @(posedge core_clk);
  endtask
  // True half then inverted half; equal halves keep duty at fifty percent
  task automatic sendBit(input logic b);
    halfOut(b);
    halfOut(!b);
  endtask
  // Bytes and nibbles go most significant bit first
  task automatic sendByte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) sendBit(v[i]);
  endtask
  task automatic sendNib(input logic [3:0] v);
    for (int i = 3; i >= 0; i--) sendBit(v[i]);
  endtask
  // Two equal NRZ bits close the telegram, then the line moves on
  task automatic sendEom();
    repeat (4) halfOut(line);
    line <= !line;
  endtask
endmodule
`default_nettype wire
